// ===== rtl/uartpc_pkg.sv
// Package for the serial transceiver: modes, field layouts, timing constants
package uartpc_pkg;
  typedef enum logic [1:0] {UARTPC_STD, UARTPC_SMART, UARTPC_IRDA} uartpc_mode_t;
  typedef enum logic [1:0] {UARTPC_TXRX, UARTPC_RXONLY, UARTPC_TXONLY} uartpc_dir_t;
  typedef enum logic [1:0] {UARTPC_PAR_NONE, UARTPC_PAR_ODD, UARTPC_PAR_EVEN} uartpc_par_t;
  typedef enum logic [1:0] {UARTPC_STOP_1, UARTPC_STOP_1P5, UARTPC_STOP_2} uartpc_stop_t;

  localparam int UARTPC_CLK_HZ       = 100000000;
  localparam int UARTPC_BAUD_MAX     = 921600;
  localparam int UARTPC_BAUD_DEF     = 115200;
  localparam int UARTPC_OVS_MIN      = 8;
  localparam int UARTPC_OVS_MAX      = 16;
  localparam int UARTPC_OVS_DEF      = 12;
  localparam int UARTPC_BITS_MIN     = 5;
  localparam int UARTPC_BITS_DEF     = 8;
  localparam int UARTPC_BITS_ADDR    = 9;
  localparam int UARTPC_FIFO_DEPTH   = 8;
  localparam int UARTPC_MEDIAN_TAPS  = 3;
  localparam int UARTPC_DIV_W        = 16;

  // Register offsets (word addresses on the plain port)
  localparam logic [3:0] UARTPC_A_CTRL   = 4'h0;
  localparam logic [3:0] UARTPC_A_DIV    = 4'h1;
  localparam logic [3:0] UARTPC_A_FIFOLV = 4'h2;
  localparam logic [3:0] UARTPC_A_TXDATA = 4'h3;
  localparam logic [3:0] UARTPC_A_RXDATA = 4'h4;
  localparam logic [3:0] UARTPC_A_STATUS = 4'h5;
  localparam logic [3:0] UARTPC_A_PINRD  = 4'h6;

  // Control field positions
  localparam int UARTPC_C_EN     = 0;
  localparam int UARTPC_C_MODE   = 1;
  localparam int UARTPC_C_PAR    = 3;
  localparam int UARTPC_C_STOP   = 5;
  localparam int UARTPC_C_BITS   = 7;
  localparam int UARTPC_C_OVS    = 11;
  localparam int UARTPC_C_CTS    = 16;
  localparam int UARTPC_C_RTS    = 17;
  localparam int UARTPC_C_RTSPOL = 18;
  localparam int UARTPC_C_MED    = 19;
  localparam int UARTPC_C_WAKE   = 20;
  localparam int UARTPC_C_SLEEP  = 21;
  localparam int UARTPC_C_EXTCLK = 22;
  localparam int UARTPC_C_INBUF  = 23;
  localparam int UARTPC_C_ADDR   = 24;

  // Default divider: clk / (baud * oversampling) - 1, integer only
  localparam logic [UARTPC_DIV_W-1:0] UARTPC_DIV_RST =
    UARTPC_DIV_W'(UARTPC_CLK_HZ / (UARTPC_BAUD_DEF * UARTPC_OVS_DEF) - 1);

  typedef struct packed {
    logic         en;
    uartpc_mode_t mode;
    uartpc_par_t  par;
    uartpc_stop_t stop;
    logic [3:0]   bits;
    logic [4:0]   ovs;
    logic         cts_en;
    logic         rts_en;
    logic         rts_pol;
    logic         med_en;
    logic         wake_en;
    logic         sleep;
    logic         ext_clk;
    logic         in_buf;
    logic         addr_bit;
  } uartpc_cfg_t;

  localparam uartpc_cfg_t UARTPC_CFG_RST = '{
    en: 1'b0, mode: UARTPC_STD, par: UARTPC_PAR_NONE, stop: UARTPC_STOP_1,
    bits: 4'(UARTPC_BITS_DEF), ovs: 5'(UARTPC_OVS_DEF), cts_en: 1'b0, rts_en: 1'b0,
    rts_pol: 1'b0, med_en: 1'b0, wake_en: 1'b0, sleep: 1'b0, ext_clk: 1'b0,
    in_buf: 1'b0, addr_bit: 1'b0};
endpackage

// ===== rtl/uartpc_top.sv
// Serial transceiver with pins, flow control, DMA level triggers and config
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module uartpc_top
  import uartpc_pkg::*;
#(
  parameter int  DEPTH    = uartpc_pkg::UARTPC_FIFO_DEPTH,
  parameter bit  HAS_RX   = 1'b1,
  parameter bit  HAS_TX   = 1'b1,
  parameter bit  RX_TRIG  = 1'b1,
  parameter bit  TX_TRIG  = 1'b1
)(
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        ext_tick,
  input  wire logic        rx_in,
  input  wire logic        cts_in,
  input  wire logic        rx_tx_in,
  output logic             rx_tx_out,
  output logic             rx_tx_oe,
  output logic             tx_out,
  output logic             rts_out,
  output logic             wake_out,
  output logic             rx_dma_request,
  output logic             tx_dma_request
);
  import uartpc_pkg::*;

  localparam int PW = $clog2(DEPTH + 1);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int FW = 10;

  typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} uartpc_st_t;

  uartpc_cfg_t            cfg_r;
  logic [UARTPC_DIV_W-1:0] div_r;
  logic [PW-1:0]          rx_lvl_r, tx_lvl_r;
  logic [UARTPC_DIV_W-1:0] divcnt_r;
  logic                   tick;
  logic                   active;
  logic                   rx_s1_r, rx_s2_r, cts_s1_r, cts_s2_r, sc_s1_r, sc_s2_r;
  logic [2:0]             med_r;
  logic                   rx_line, rx_prev_r, med_on;
  logic [8:0]             tx_mem [DEPTH];
  logic [8:0]             rx_mem [DEPTH];
  logic [AW-1:0]          tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic [PW-1:0]          tx_cnt_r, rx_cnt_r;
  logic                   tx_push, tx_pop, rx_push, rx_pop;
  uartpc_st_t             tst_r, rst_r;
  logic [4:0]             tovs_r, rovs_r;
  logic [3:0]             tbit_r, rbit_r;
  logic [FW-1:0]          tsh_r;
  logic [FW-1:0]          rsh_r;
  logic                   tline_r;
  logic                   rx_err_r;
  logic [3:0]             nbits_tx, nbits_rx;

  // Parity of a frame's payload as configured
  function automatic logic par_bit(input logic [8:0] d, input logic [3:0] n,
                                   input uartpc_par_t p);
    logic x;
    x = 1'b0;
    for (int i = 0; i < 9; i++)
      if (i < int'(n))
        x = x ^ d[i];
    par_bit = (p == UARTPC_PAR_ODD) ? ~x : x;
  endfunction

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  // Payload width: nine-bit mode carries eight plus the flag
  function automatic logic [3:0] pay_bits(input logic [3:0] b);
    pay_bits = (b >= 4'(UARTPC_BITS_ADDR)) ? 4'(UARTPC_BITS_DEF) : b;
  endfunction

  function automatic logic [4:0] ovs_clamp(input logic [4:0] o);
    ovs_clamp = (o < 5'(UARTPC_OVS_MIN)) ? 5'(UARTPC_OVS_MIN) :
                (o > 5'(UARTPC_OVS_MAX)) ? 5'(UARTPC_OVS_MAX) : o;
  endfunction

  assign active = cfg_r.en && !cfg_r.sleep;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_r    <= UARTPC_CFG_RST;
      div_r    <= UARTPC_DIV_RST;
      rx_lvl_r <= '0;
      tx_lvl_r <= '0;
    end
    else if (reg_wr && reg_addr == UARTPC_A_CTRL)
    begin
      cfg_r.en       <= reg_wdata[UARTPC_C_EN];
      cfg_r.mode     <= (reg_wdata[UARTPC_C_MODE+:2] > 2'(UARTPC_IRDA)) ? UARTPC_STD
                        : uartpc_mode_t'(reg_wdata[UARTPC_C_MODE+:2]);
      cfg_r.par      <= (reg_wdata[UARTPC_C_PAR+:2] > 2'(UARTPC_PAR_EVEN)) ? UARTPC_PAR_NONE
                        : uartpc_par_t'(reg_wdata[UARTPC_C_PAR+:2]);
      cfg_r.stop     <= (reg_wdata[UARTPC_C_STOP+:2] > 2'(UARTPC_STOP_2)) ? UARTPC_STOP_1
                        : uartpc_stop_t'(reg_wdata[UARTPC_C_STOP+:2]);
      cfg_r.bits     <= (reg_wdata[UARTPC_C_BITS+:4] < 4'(UARTPC_BITS_MIN) ||
                         reg_wdata[UARTPC_C_BITS+:4] > 4'(UARTPC_BITS_ADDR)) ?
                        4'(UARTPC_BITS_DEF) : reg_wdata[UARTPC_C_BITS+:4];
      cfg_r.ovs      <= ovs_clamp(reg_wdata[UARTPC_C_OVS+:5]);
      cfg_r.cts_en   <= reg_wdata[UARTPC_C_CTS];
      cfg_r.rts_en   <= reg_wdata[UARTPC_C_RTS];
      cfg_r.rts_pol  <= reg_wdata[UARTPC_C_RTSPOL];
      cfg_r.med_en   <= reg_wdata[UARTPC_C_MED];
      cfg_r.wake_en  <= reg_wdata[UARTPC_C_WAKE];
      cfg_r.sleep    <= reg_wdata[UARTPC_C_SLEEP];
      cfg_r.ext_clk  <= reg_wdata[UARTPC_C_EXTCLK];
      cfg_r.in_buf   <= reg_wdata[UARTPC_C_INBUF];
      cfg_r.addr_bit <= reg_wdata[UARTPC_C_ADDR];
    end
    else if (reg_wr && reg_addr == UARTPC_A_DIV)
      div_r <= reg_wdata[UARTPC_DIV_W-1:0];
    else if (reg_wr && reg_addr == UARTPC_A_FIFOLV)
    begin
      rx_lvl_r <= reg_wdata[PW-1:0];
      tx_lvl_r <= reg_wdata[16+:PW];
    end
  end

  // integer divider, external tick bypasses it
  always_ff @(posedge clk)
  begin
    if (srst || !active || divcnt_r == '0)
      divcnt_r <= div_r;
    else
      divcnt_r <= divcnt_r - UARTPC_DIV_W'(1);
  end
  assign tick = active && (cfg_r.ext_clk ? ext_tick : (divcnt_r == '0));

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      {rx_s1_r, rx_s2_r, sc_s1_r, sc_s2_r} <= 4'hF;
      {cts_s1_r, cts_s2_r} <= 2'h0;
    end
    else
    begin
      rx_s1_r  <= rx_in;
      rx_s2_r  <= rx_s1_r;
      sc_s1_r  <= rx_tx_in;
      sc_s2_r  <= sc_s1_r;
      cts_s1_r <= cts_in;
      cts_s2_r <= cts_s1_r;
    end
  end

  assign med_on = cfg_r.med_en || (cfg_r.mode == UARTPC_IRDA);
  always_ff @(posedge clk)
  begin
    if (srst)
      med_r <= '1;
    else
      med_r <= {med_r[1:0], (cfg_r.mode == UARTPC_SMART) ? sc_s2_r : rx_s2_r};
  end
  assign rx_line = med_on ? ((med_r[0] & med_r[1]) | (med_r[1] & med_r[2]) |
                             (med_r[0] & med_r[2])) : med_r[0];

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_prev_r <= 1'b1;
      wake_out  <= 1'b0;
    end
    else
    begin
      rx_prev_r <= rx_line;
      wake_out  <= HAS_RX && cfg_r.wake_en && rx_prev_r && !rx_line;
    end
  end

  a_wake_gate: assert property (@(posedge clk) disable iff (srst)
    wake_out |-> $past(cfg_r.wake_en)) else $error("wake without enable");

  assign nbits_tx = pay_bits(cfg_r.bits);
  assign nbits_rx = pay_bits(cfg_r.bits);
  assign tx_push  = HAS_TX && reg_wr && reg_addr == UARTPC_A_TXDATA &&
                    tx_cnt_r != PW'(DEPTH);
  assign rx_pop   = HAS_RX && reg_rd && reg_addr == UARTPC_A_RXDATA && rx_cnt_r != '0;

  // TX FIFO
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_wp_r  <= '0;
      tx_rp_r  <= '0;
      tx_cnt_r <= '0;
    end
    else
    begin
      if (tx_push)
      begin
        tx_mem[tx_wp_r] <= {cfg_r.addr_bit, reg_wdata[7:0]};
        tx_wp_r <= ptr_inc(tx_wp_r);
      end
      if (tx_pop)
        tx_rp_r <= ptr_inc(tx_rp_r);
      tx_cnt_r <= tx_cnt_r + PW'(tx_push) - PW'(tx_pop);
    end
  end

  // Transmitter; frame = start, data, parity/flag, stop
  // CTS gates start of frame only
  assign tx_pop = HAS_TX && active && tick && tst_r == S_IDLE && tx_cnt_r != '0 &&
                  (!cfg_r.cts_en || cts_s2_r);
  always_ff @(posedge clk)
  begin
    if (srst || !active)
    begin
      tst_r   <= S_IDLE;
      tline_r <= 1'b1;
      tovs_r  <= '0;
      tbit_r  <= '0;
      tsh_r   <= '1;
    end
    else if (tx_pop)
    begin
      tst_r   <= S_START;
      tline_r <= 1'b0;
      tovs_r  <= '0;
      tbit_r  <= '0;
      // nine-bit puts flag in parity slot
      tsh_r   <= {1'b1, 9'(tx_mem[tx_rp_r][7:0])};
      if (cfg_r.bits == 4'(UARTPC_BITS_ADDR))
        tsh_r[nbits_tx] <= tx_mem[tx_rp_r][8];
      else if (cfg_r.par != UARTPC_PAR_NONE)
        tsh_r[nbits_tx] <= par_bit(tx_mem[tx_rp_r], nbits_tx, cfg_r.par);
    end
    else if (tick && tst_r != S_IDLE)
    begin
      tovs_r <= tovs_r + 5'd1;
      if (tovs_r == cfg_r.ovs - 5'd1)
      begin
        tovs_r <= '0;
        unique case (tst_r)
          S_START, S_DATA:
          begin
            tline_r <= tsh_r[0];
            tsh_r   <= {1'b1, tsh_r[FW-1:1]};
            tbit_r  <= tbit_r + 4'd1;
            if (tbit_r == nbits_tx + 4'((cfg_r.bits == 4'(UARTPC_BITS_ADDR)) ||
                                        (cfg_r.par != UARTPC_PAR_NONE)))
            begin
              tst_r  <= S_STOP;
              tline_r <= 1'b1;
              tbit_r <= '0;
            end
            else
              tst_r <= S_DATA;
          end
          S_STOP:
          begin
            tbit_r <= tbit_r + 4'd2;
            if (tbit_r + 4'd2 >= 4'(2 + int'(cfg_r.stop)))
              tst_r <= S_IDLE;
          end
          default: tst_r <= S_IDLE;
        endcase
      end
      else if (tst_r == S_STOP && cfg_r.stop == UARTPC_STOP_1P5 &&
               tbit_r == 4'd2 && tovs_r == (cfg_r.ovs >> 1) - 5'd1)
        tst_r <= S_IDLE;
    end
  end

  // Start bit reaches the pin one cycle after the shifter
  sequence s_start_low;
    !tline_r ##1 !tx_out;
  endsequence
  a_tx_start: assert property (@(posedge clk) disable iff (srst)
    tx_pop && cfg_r.mode != UARTPC_SMART |=> s_start_low) else $error("no start bit");
  a_idle_high: assert property (@(posedge clk) disable iff (srst)
    tst_r == S_IDLE |-> tline_r) else $error("idle line low");
  a_cts_hold: assert property (@(posedge clk) disable iff (srst)
    tst_r == S_IDLE && cfg_r.cts_en && !cts_s2_r |=> tst_r == S_IDLE)
    else $error("frame started without cts");

  // Receiver: centre sampling, stores payload and flag
  always_ff @(posedge clk)
  begin
    if (srst || !active || !HAS_RX)
    begin
      rst_r   <= S_IDLE;
      rovs_r  <= '0;
      rbit_r  <= '0;
      rsh_r   <= '0;
      rx_push <= 1'b0;
      rx_err_r <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      if (tick)
      begin
        rovs_r <= rovs_r + 5'd1;
        unique case (rst_r)
          S_IDLE:
            if (!rx_line)
            begin
              rst_r  <= S_START;
              rovs_r <= '0;
            end
          S_START:
            if (rovs_r == (cfg_r.ovs >> 1))
            begin
              rst_r  <= rx_line ? S_IDLE : S_DATA;
              rovs_r <= '0;
              rbit_r <= '0;
            end
          S_DATA:
            if (rovs_r == cfg_r.ovs - 5'd1)
            begin
              rovs_r <= '0;
              rsh_r[rbit_r] <= rx_line;
              rbit_r <= rbit_r + 4'd1;
              if (rbit_r == nbits_rx + 4'((cfg_r.bits == 4'(UARTPC_BITS_ADDR)) ||
                                          (cfg_r.par != UARTPC_PAR_NONE)))
                rst_r <= S_STOP;
            end
          S_STOP:
          begin
            rst_r   <= S_IDLE;
            rx_push <= rx_cnt_r != PW'(DEPTH);
            rx_err_r <= (cfg_r.par != UARTPC_PAR_NONE && cfg_r.bits != 4'(UARTPC_BITS_ADDR))
                        && (rsh_r[nbits_rx] != par_bit(rsh_r[8:0], nbits_rx, cfg_r.par));
          end
          default: rst_r <= S_IDLE;
        endcase
      end
    end
  end

  // RX FIFO
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rx_wp_r  <= '0;
      rx_rp_r  <= '0;
      rx_cnt_r <= '0;
    end
    else
    begin
      if (rx_push)
      begin
        // flag only in nine-bit mode; otherwise parity or stop sits there
        rx_mem[rx_wp_r] <= {(cfg_r.bits == 4'(UARTPC_BITS_ADDR)) && rsh_r[nbits_rx],
                            rsh_r[7:0] & 8'(9'h1FF >> (9 - int'(nbits_rx)))};
        rx_wp_r <= ptr_inc(rx_wp_r);
      end
      if (rx_pop)
        rx_rp_r <= ptr_inc(rx_rp_r);
      rx_cnt_r <= rx_cnt_r + PW'(rx_push) - PW'(rx_pop);
    end
  end

  // Pins
  // tx idles high, only std/IrDA with TX
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_out    <= 1'b1;
      rts_out   <= 1'b0;
      rx_tx_oe  <= 1'b0;
    end
    else
    begin
      tx_out   <= !(HAS_TX && active && cfg_r.mode != UARTPC_SMART) || tline_r;
      rx_tx_oe <= HAS_TX && active && cfg_r.mode == UARTPC_SMART && !tline_r;
      rts_out  <= (HAS_RX && active && cfg_r.rts_en && rx_cnt_r != PW'(DEPTH))
                  ? !cfg_r.rts_pol : cfg_r.rts_pol;
    end
  end
  assign rx_tx_out = 1'b0;
  a_card_drive: assert property (@(posedge clk) disable iff (srst)
    cfg_r.mode != UARTPC_SMART |=> !rx_tx_oe) else $error("card line driven");
  a_card_tx_off: assert property (@(posedge clk) disable iff (srst)
    cfg_r.mode == UARTPC_SMART |=> tx_out) else $error("tx active in card mode");

  assign rx_dma_request = RX_TRIG && HAS_RX && (rx_cnt_r > rx_lvl_r);
  assign tx_dma_request = TX_TRIG && HAS_TX && (tx_cnt_r < tx_lvl_r);

  // Register read; pin readback zero unless buffer enabled
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= '0;
    else if (reg_rd)
      unique case (reg_addr)
        // Same field layout as the write
        UARTPC_A_CTRL:   reg_rdata <= {7'h00, cfg_r.addr_bit, cfg_r.in_buf, cfg_r.ext_clk,
                                       cfg_r.sleep, cfg_r.wake_en, cfg_r.med_en, cfg_r.rts_pol,
                                       cfg_r.rts_en, cfg_r.cts_en, cfg_r.ovs, cfg_r.bits,
                                       cfg_r.stop, cfg_r.par, cfg_r.mode, cfg_r.en};
        UARTPC_A_DIV:    reg_rdata <= 32'(div_r);
        UARTPC_A_FIFOLV: reg_rdata <= {16'(tx_lvl_r), 16'(rx_lvl_r)};
        UARTPC_A_RXDATA: reg_rdata <= (rx_cnt_r != '0) ? 32'(rx_mem[rx_rp_r]) : '0;
        UARTPC_A_STATUS: reg_rdata <= {rx_err_r, 7'h00, 8'(tx_cnt_r), 8'(rx_cnt_r),
                                       6'h00, tst_r != S_IDLE, rst_r != S_IDLE};
        UARTPC_A_PINRD:  reg_rdata <= cfg_r.in_buf ? {30'h0, rts_out, tx_out} : '0;
        default:         reg_rdata <= '0;
      endcase
    else
      reg_rdata <= '0;
  end

  a_idle_pins: assert property (@(posedge clk) disable iff (srst)
    !active |=> tx_out && (rts_out == cfg_r.rts_pol)) else $error("pins not inactive");
endmodule // uartpc_top

// ===== testbench/uartpc_far_end.sv
// Far serial device model: drives the receive line and cts, decodes frames
`timescale 1ns/1ns
module uartpc_far_end
(
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out,
  output logic      ready
);
  initial
  begin
    line_out = 1'b1;
    ready    = 1'b0;
  end

  task automatic set_ready(input logic v);
    ready <= v;
    @(posedge clk);
  endtask

  // line left high after the stop bit
  task automatic send(input logic [10:0] f, input int n, input int bclk);
    for (int i = 0; i < n; i++)
    begin
      line_out <= f[i];
      repeat (bclk) @(posedge clk);
    end
  endtask

  // Mid-bit sampling; returns at the last stop sample so frames may follow at once
  task automatic recv(input int n, input int bclk, output logic [10:0] f);
    int w;
    w = 0;
    f = '1;
    while (line_in !== 1'b0 && w < 4000)
    begin
      @(posedge clk);
      w++;
    end
    repeat (bclk / 2) @(posedge clk);
    for (int i = 0; i < n; i++)
    begin
      f[i] = line_in;
      if (i < n - 1)
        repeat (bclk) @(posedge clk);
    end
  endtask
endmodule // uartpc_far_end

// ===== testbench/uartpc_top_bench.sv
// Self-checking bench for the serial transceiver with a far-end model
`timescale 1ns/1ns
module uartpc_top_bench;
  import uartpc_pkg::*;

  typedef struct packed {
    logic [3:0]   bits;
    uartpc_par_t  par;
    uartpc_stop_t stop;
    logic         ext;
    logic         abit;
    logic [7:0]   data;
  } uartpc_row_t;

  localparam int         BCLK   = 8;
  localparam logic [8:0] F_CTS  = 9'h001;
  localparam logic [8:0] F_RTS  = 9'h002;
  localparam logic [8:0] F_POL  = 9'h004;
  localparam logic [8:0] F_WAKE = 9'h010;
  localparam logic [8:0] F_SLP  = 9'h020;
  localparam logic [8:0] F_EXT  = 9'h040;
  localparam logic [8:0] F_INB  = 9'h080;
  localparam logic [8:0] F_ADDR = 9'h100;
  localparam uartpc_row_t ROWS [6] = '{
    '{4'h8, UARTPC_PAR_NONE, UARTPC_STOP_1, 1'b0, 1'b0, 8'hA5},
    '{4'h5, UARTPC_PAR_ODD, UARTPC_STOP_1, 1'b0, 1'b0, 8'h13},
    '{4'h7, UARTPC_PAR_EVEN, UARTPC_STOP_2, 1'b0, 1'b0, 8'h5A},
    '{4'h6, UARTPC_PAR_EVEN, UARTPC_STOP_1P5, 1'b0, 1'b0, 8'h2C},
    '{4'h9, UARTPC_PAR_NONE, UARTPC_STOP_1, 1'b0, 1'b1, 8'hC3},
    '{4'h8, UARTPC_PAR_ODD, UARTPC_STOP_1, 1'b1, 1'b0, 8'h80}};

  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        ext_tick  = 1'b1;
  logic        smart     = 1'b0;
  logic        tx_dip    = 1'b0;
  logic [4:0]  ovs_sel   = 5'h8;
  logic [31:0] reg_rdata;
  logic        far_line, cts_in, rx_tx_out, rx_tx_oe, tx_out, rts_out, wake_out;
  logic        rx_dma_request, tx_dma_request;
  int          error_cnt = 0;
  int          n_tests   = 0;
  int          wake_cnt  = 0;
  // Pull-up on the shared card line; either side may only pull low
  wire         rx_tx_wire = ~rx_tx_oe & far_line;

  always #5 clk = ~clk;

  always @(posedge clk)
  begin
    if (wake_out === 1'b1)
      wake_cnt++;
    if (smart && tx_out !== 1'b1)
      tx_dip = 1'b1;
  end

  uartpc_top dut
  (
    .clk            (clk),
    .srst           (srst),
    .reg_addr       (reg_addr),
    .reg_wdata      (reg_wdata),
    .reg_wr         (reg_wr),
    .reg_rd         (reg_rd),
    .reg_rdata      (reg_rdata),
    .ext_tick       (ext_tick),
    .rx_in          (far_line),
    .cts_in         (cts_in),
    .rx_tx_in       (rx_tx_wire),
    .rx_tx_out      (rx_tx_out),
    .rx_tx_oe       (rx_tx_oe),
    .tx_out         (tx_out),
    .rts_out        (rts_out),
    .wake_out       (wake_out),
    .rx_dma_request (rx_dma_request),
    .tx_dma_request (tx_dma_request)
  );

  uartpc_far_end far
  (
    .clk      (clk),
    .line_in  (smart ? rx_tx_wire : tx_out),
    .line_out (far_line),
    .ready    (cts_in)
  );

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, 32'(e), 32'(g));
  endtask

  task automatic rchk(input string nm, input logic [3:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask

  function automatic logic [31:0] cw(input logic en, input logic [1:0] m, p, s,
                                     input logic [3:0] b, input logic [8:0] fl);
    return {7'h00, fl, ovs_sel, b, s, p, m, en};
  endfunction

  task automatic std(input logic en, input logic [8:0] fl);
    wr(UARTPC_A_CTRL, cw(en, UARTPC_STD, UARTPC_PAR_NONE, UARTPC_STOP_1, 4'h8, fl));
  endtask

  function automatic logic [10:0] frame(input uartpc_row_t r, output int n,
                                        output logic [8:0] d);
    logic [10:0] f;
    d = {r.abit, r.data} & ((9'h001 << r.bits) - 9'h001);
    f = '1;
    f[0] = 1'b0;
    for (int i = 0; i < int'(r.bits); i++)
      f[1 + i] = d[i];
    n = 1 + int'(r.bits);
    if (r.par != UARTPC_PAR_NONE)
    begin
      f[n] = (r.par == UARTPC_PAR_ODD) ? ~^d : ^d;
      n++;
    end
    n++;
    return f;
  endfunction

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    uartpc_row_t r;
    logic [10:0] f, g;
    logic [8:0]  d;
    logic [31:0] c;
    int          n;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    tick(1);
    chb("tx idle", 1'b1, tx_out);
    chb("rts reset", 1'b0, rts_out);
    chb("card oe", 1'b0, rx_tx_oe);
    ovs_sel = 5'(UARTPC_OVS_DEF);
    c = cw(1'b0, UARTPC_STD, UARTPC_PAR_NONE, UARTPC_STOP_1, 4'(UARTPC_BITS_DEF), 9'h0);
    ovs_sel = 5'(UARTPC_OVS_MIN);
    rchk("ctrl reset", UARTPC_A_CTRL, c);
    rchk("div reset", UARTPC_A_DIV, UARTPC_CLK_HZ / (UARTPC_BAUD_DEF * UARTPC_OVS_DEF) - 1);
    rchk("pin read", UARTPC_A_PINRD, 32'h0);
    wr(4'hF, 32'hFFFFFFFF);
    rchk("unmapped", UARTPC_A_CTRL, c);
    for (int m = 0; m < 3; m++)
    begin
      c = cw(1'b0, 2'(m), UARTPC_PAR_NONE, UARTPC_STOP_1, 4'h8, 9'h0);
      wr(UARTPC_A_CTRL, c);
      rchk("mode", UARTPC_A_CTRL, c);
    end
    wr(UARTPC_A_FIFOLV, 32'h0);
    foreach (ROWS[i])
    begin
      r = ROWS[i];
      // External tick at every clock makes the divider irrelevant
      wr(UARTPC_A_DIV, r.ext ? 32'h9 : 32'h0);
      wr(UARTPC_A_CTRL, cw(1'b1, UARTPC_STD, r.par, r.stop, r.bits,
                           (r.ext ? F_EXT : 9'h0) | (r.abit ? F_ADDR : 9'h0)));
      f = frame(r, n, d);
      fork
        far.recv(n, BCLK, g);
        wr(UARTPC_A_TXDATA, 32'(r.data));
      join
      chk("tx frame", 32'(f), 32'(g));
      far.send(f, n, BCLK);
      tick(4);
      rchk("rx data", UARTPC_A_RXDATA, 32'(d));
    end
    wr(UARTPC_A_DIV, 32'h0);
    smart <= 1'b1;
    wr(UARTPC_A_CTRL, cw(1'b1, UARTPC_SMART, UARTPC_PAR_NONE, UARTPC_STOP_1, 4'h8, 9'h0));
    f = frame(ROWS[0], n, d);
    fork
      far.recv(n, BCLK, g);
      wr(UARTPC_A_TXDATA, 32'(ROWS[0].data));
    join
    chk("card frame", 32'(f), 32'(g));
    chb("tx quiet", 1'b0, tx_dip);
    chb("card drive", 1'b0, rx_tx_out);
    // Shared line: the receiver hears its own frame
    tick(8);
    rchk("card echo", UARTPC_A_RXDATA, 32'(d));
    smart <= 1'b0;
    wr(UARTPC_A_FIFOLV, 32'h0002_0003);
    std(1'b1, F_CTS);
    tick(2);
    chb("tx dma empty", 1'b1, tx_dma_request);
    for (int i = 0; i < 3; i++)
      wr(UARTPC_A_TXDATA, 32'(i + 48));
    chb("tx dma held", 1'b0, tx_dma_request);
    tick(4 * BCLK * 11);
    rd(UARTPC_A_STATUS, c);
    chk("cts gate", 32'h3, 32'(c[23:16]));
    far.set_ready(1'b1);
    for (int i = 0; i < 3; i++)
    begin
      far.recv(10, BCLK, g);
      chk("cts frame", 32'({2'b11, 8'(i + 48), 1'b0}), 32'(g));
    end
    chb("tx dma drained", 1'b1, tx_dma_request);
    std(1'b1, F_RTS);
    tick(2);
    chb("rts ready", 1'b1, rts_out);
    for (int i = 0; i < 8; i++)
    begin
      far.send({2'b11, 8'(i + 64), 1'b0}, 10, BCLK);
      tick(4);
      chb("rx dma", i >= 3, rx_dma_request);
    end
    chb("rts full", 1'b0, rts_out);
    std(1'b1, F_RTS | F_POL);
    tick(2);
    chb("rts polarity", 1'b1, rts_out);
    for (int i = 0; i < 8; i++)
      rchk("rx order", UARTPC_A_RXDATA, 32'(i + 64));
    tick(2);
    chb("rx dma low", 1'b0, rx_dma_request);
    chb("rts pol ready", 1'b0, rts_out);
    rchk("rx empty", UARTPC_A_RXDATA, 32'h0);
    std(1'b0, F_RTS | F_POL | F_INB);
    tick(2);
    chb("off tx", 1'b1, tx_out);
    chb("off rts", 1'b1, rts_out);
    rchk("pin buffer", UARTPC_A_PINRD, 32'h3);
    std(1'b1, F_RTS | F_POL | F_SLP);
    tick(2);
    chb("sleep rts", 1'b1, rts_out);
    chk("no wake", 32'h0, 32'(wake_cnt));
    std(1'b1, F_RTS | F_POL | F_SLP | F_WAKE);
    far.send({2'b11, 8'hFF, 1'b0}, 10, BCLK);
    tick(4);
    chk("wake pulse", 32'h1, 32'(wake_cnt));
    chb("sleep tx", 1'b1, tx_out);
    report_and_stop();
  end
endmodule // uartpc_top_bench
